// ==== rtl/dram_ctrl.sv ====
// Host-side controller that drives the strobes, address and data pins of the memory.
`timescale 1ns/100ps
// Operation
// - Word address goes out as row half then column half on mux_address.
// - Row-to-column delay kept at least 30 ns and no more than 75 ns.
// - The strobe states select read, write, modify-write or standby.
// - Page mode pulses column strobe under one held row strobe.
// - All 128 rows are refreshed within every 2 ms.
// - Avoid refresh by read or write on a wired-OR output bus.
// - Refresh-only cycles drive row strobe alone with a row address.
// - Hidden refresh cycles row strobe with column strobe held low.
// - A shared data bus needs every write in early-write timing; the modify-write cycle here uses a late write strobe.
// - Either strobe may be decoded as chip select.
// - Wait about 500 us then eight dummy cycles before real use.
module dram_ctrl
	import dram_ctrl_pkg::*;
#(
	parameter int POWERUP_CYCLES = POWERUP_CYC,
	parameter int REFRESH_INTERVAL = REFRESH_INTERVAL_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// User request.
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_cmd,
	input wire logic [dram_ctrl_pkg::ADDR_W-1:0] req_addr,
	input wire logic [dram_ctrl_pkg::DATA_W-1:0] req_wdata,
	input wire logic req_page,
	// User answer.
	output logic rsp_valid,
	output logic [dram_ctrl_pkg::DATA_W-1:0] rsp_rdata,
	output logic init_done,
	// Memory pins.
	output logic row_strobe_n,
	output logic column_strobe_n,
	output logic write_strobe_n,
	output logic [dram_ctrl_pkg::HALF_W-1:0] mux_address,
	output logic [dram_ctrl_pkg::DATA_W-1:0] write_data_in,
	input wire logic [dram_ctrl_pkg::DATA_W-1:0] read_data_out
);
	import dram_ctrl_pkg::*;

	typedef enum logic [3:0] {S_POWER, S_DUMMY_LO, S_DUMMY_HI, S_IDLE, S_RAS, S_CAS,
		S_RMW_WR, S_CAS_HI, S_PRE} state_t;

	state_t state_ff;
	logic [CNT_W-1:0] cnt_ff;
	logic [3:0] dummy_ff;
	logic [CNT_W-1:0] ref_tick_ff;
	logic ref_pend_ff;
	logic [ROW_LOW_W-1:0] ref_row_ff;
	op_t op_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [DATA_W-1:0] sync1_ff;
	logic [DATA_W-1:0] sync2_ff;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n - 1);
	endfunction

	wire cnt_zero = (cnt_ff == '0);

	// Incoming read data passes two flip-flops.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end
		else
		begin
			sync1_ff <= read_data_out;
			sync2_ff <= sync1_ff;
		end
	end

	// Refresh interval timer; the pending flag sets ahead of its clear.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ref_tick_ff <= '0;
			ref_pend_ff <= 1'b0;
		end
		else
		begin
			if (ref_tick_ff == cyc(REFRESH_INTERVAL))
				ref_tick_ff <= '0;
			else
				ref_tick_ff <= ref_tick_ff + 1'b1;
			if (ref_tick_ff == cyc(REFRESH_INTERVAL))
				ref_pend_ff <= 1'b1;
			else if (state_ff == S_IDLE)
				ref_pend_ff <= 1'b0;
		end
	end

	assign req_ready = (state_ff == S_IDLE) && !ref_pend_ff && init_done;

	// Main sequencer.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= S_POWER;
			cnt_ff <= '0;
			dummy_ff <= '0;
			ref_row_ff <= '0;
			op_ff <= OP_READ;
			addr_ff <= '0;
			row_strobe_n <= 1'b1;
			column_strobe_n <= 1'b1;
			write_strobe_n <= 1'b1;
			mux_address <= '0;
			write_data_in <= '0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			init_done <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			if (!cnt_zero)
				cnt_ff <= cnt_ff - 1'b1;
			unique case (state_ff)
				S_POWER:
					if (cnt_ff == cyc(POWERUP_CYCLES))
					begin
						state_ff <= S_DUMMY_LO;
						cnt_ff <= cyc(RAS_LOW_CYC);
						row_strobe_n <= 1'b0;
					end
					else
						cnt_ff <= cnt_ff + 1'b1;
				S_DUMMY_LO:
					if (cnt_zero)
					begin
						row_strobe_n <= 1'b1;
						dummy_ff <= dummy_ff + 1'b1;
						cnt_ff <= cyc(RAS_HIGH_CYC);
						state_ff <= S_DUMMY_HI;
					end
				S_DUMMY_HI:
					if (cnt_zero)
					begin
						if (dummy_ff == 4'(DUMMY_CYCLES))
						begin
							init_done <= 1'b1;
							state_ff <= S_IDLE;
						end
						else
						begin
							row_strobe_n <= 1'b0;
							cnt_ff <= cyc(RAS_LOW_CYC);
							state_ff <= S_DUMMY_LO;
						end
					end
				S_IDLE:
					if (ref_pend_ff)
					begin
						// Row-only refresh; the column strobe keeps its level, so outputs float when it is high.
						// After a hidden refresh entry the column strobe is low and data holds.
						op_ff <= OP_REFRESH;
						mux_address <= HALF_W'(ref_row_ff);
						ref_row_ff <= ref_row_ff + 1'b1;
						row_strobe_n <= 1'b0;
						cnt_ff <= cyc(RAS_LOW_CYC);
						state_ff <= S_RAS;
					end
					else if (req_valid && init_done)
					begin
						op_ff <= op_t'(req_cmd);
						addr_ff <= req_addr;
						write_data_in <= req_wdata;
						mux_address <= req_addr[ADDR_W-1:HALF_W];
						row_strobe_n <= 1'b0;
						// Early write: write strobe low before the column strobe.
						write_strobe_n <= (req_cmd != CMD_WRITE);
						cnt_ff <= cyc(RCD_CYC);
						state_ff <= S_RAS;
					end
				S_RAS:
					if (op_ff == OP_REFRESH)
					begin
						if (cnt_zero)
						begin
							row_strobe_n <= 1'b1;
							column_strobe_n <= 1'b1;
							cnt_ff <= cyc(RAS_HIGH_CYC);
							state_ff <= S_PRE;
						end
					end
					else if (cnt_zero)
					begin
						// Column fall lands RCD_CYC cycles (50 ns) after the row fall, inside the window.
						mux_address <= addr_ff[HALF_W-1:0];
						column_strobe_n <= 1'b0;
						cnt_ff <= cyc(ACCESS_CYC);
						state_ff <= S_CAS;
					end
				S_CAS:
					if (cnt_zero)
					begin
						if (op_ff == OP_READ || op_ff == OP_RMW)
						begin
							rsp_rdata <= sync2_ff;
							rsp_valid <= (op_ff == OP_READ);
						end
						if (op_ff == OP_RMW)
						begin
							// Late write strobe captures the new data.
							write_strobe_n <= 1'b0;
							cnt_ff <= cyc(CAS_LOW_CYC);
							state_ff <= S_RMW_WR;
						end
						else if (op_ff == OP_READ && ref_pend_ff)
						begin
							// Hidden refresh: column strobe stays low so the read data stays valid.
							row_strobe_n <= 1'b1;
							cnt_ff <= cyc(RAS_HIGH_CYC);
							state_ff <= S_PRE;
						end
						else
						begin
							column_strobe_n <= 1'b1;
							write_strobe_n <= 1'b1;
							cnt_ff <= cyc(CAS_HIGH_CYC);
							state_ff <= S_CAS_HI;
						end
					end
				S_RMW_WR:
					if (cnt_zero)
					begin
						rsp_valid <= 1'b1;
						column_strobe_n <= 1'b1;
						write_strobe_n <= 1'b1;
						cnt_ff <= cyc(CAS_HIGH_CYC);
						state_ff <= S_CAS_HI;
					end
				S_CAS_HI:
					if (cnt_zero)
					begin
						if (req_valid && req_page && !ref_pend_ff && req_addr[ADDR_W-1:HALF_W]
							== addr_ff[ADDR_W-1:HALF_W])
						begin
							// Page mode: new column under the held row.
							op_ff <= op_t'(req_cmd);
							addr_ff <= req_addr;
							write_data_in <= req_wdata;
							mux_address <= req_addr[HALF_W-1:0];
							write_strobe_n <= (req_cmd != CMD_WRITE);
							column_strobe_n <= 1'b0;
							cnt_ff <= cyc(ACCESS_CYC);
							state_ff <= S_CAS;
						end
						else
						begin
							row_strobe_n <= 1'b1;
							cnt_ff <= cyc(RAS_HIGH_CYC);
							state_ff <= S_PRE;
						end
					end
				S_PRE:
					if (cnt_zero)
						state_ff <= S_IDLE;
				default:
					state_ff <= S_IDLE;
			endcase
		end
	end

	// Ready is raised in S_IDLE only; a page request is taken in S_CAS_HI without it.
endmodule

// ==== rtl/dram_ctrl_pkg.sv ====
// Package with timing constants and command codes for the dynamic memory controller.
package dram_ctrl_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int ADDR_W = 16;
	localparam int HALF_W = 8;
	localparam int DATA_W = 8;
	localparam int ROW_LOW_W = 7;
	// Strobe, refresh and power-up timing in nanoseconds, then refresh row and dummy cycle counts.
	localparam int T_RCD_MIN_NS = 30;
	localparam int T_RCD_MAX_NS = 75;
	localparam int T_RAS_LOW_NS = 150;
	localparam int T_RAS_HIGH_NS = 100;
	localparam int T_CAS_LOW_NS = 75;
	localparam int T_CAS_HIGH_NS = 35;
	localparam int T_ACCESS_NS = 150;
	localparam int T_REFRESH_NS = 2000000;
	localparam int T_POWERUP_NS = 500000;
	localparam int REFRESH_ROWS = 128;
	localparam int DUMMY_CYCLES = 8;
	// Cycle counts; least times round up, the refresh period rounds down.
	localparam int RCD_CYC = (T_RCD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAS_LOW_CYC = (T_RAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAS_HIGH_CYC = (T_RAS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_LOW_CYC = (T_CAS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAS_HIGH_CYC = (T_CAS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int REFRESH_INTERVAL_CYC = T_REFRESH_NS / REFRESH_ROWS / CLK_PERIOD_NS;
	localparam int POWERUP_CYC = (T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 16;
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_RMW = 2'h2;
	typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_RMW, OP_REFRESH} op_t;
endpackage

// ==== verification/dram_ctrl_monitor.sv ====
// Checker of strobe sequencing at the controller ports.
`timescale 1ns/100ps
module dram_ctrl_monitor
	import dram_ctrl_pkg::*;
#(
	parameter int REFRESH_INTERVAL = REFRESH_INTERVAL_CYC
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// User side.
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [1:0] req_cmd,
	input wire logic [dram_ctrl_pkg::ADDR_W-1:0] req_addr,
	input wire logic rsp_valid,
	input wire logic init_done,
	// Memory pins.
	input wire logic row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [dram_ctrl_pkg::HALF_W-1:0] mux_address
);
	import dram_ctrl_pkg::*;
	logic [15:0] gap_ff;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge clk or posedge rst)
		if (rst)
			gap_ff <= 16'h0;
		else if (!init_done || $fell(row_strobe_n))
			gap_ff <= 16'h0;
		else
			gap_ff <= gap_ff + 16'h1;
	sequence s_row_open;
		$fell(row_strobe_n) && $past(req_valid && req_ready);
	endsequence
	sequence s_row_only;
		$fell(row_strobe_n) && !$past(req_valid && req_ready) && init_done;
	endsequence
	sequence s_col_open;
		$fell(column_strobe_n) && mux_address == $past(req_addr[7:0], 3);
	endsequence
	property p_addr;
		s_row_open |-> mux_address == $past(req_addr[15:8]) ##2 s_col_open;
	endproperty
	a_addr: assert property (p_addr) else $error("row or column half misplaced");
	property p_rcd;
		$fell(column_strobe_n) |-> !$past(row_strobe_n, 2);
	endproperty
	a_rcd: assert property (p_rcd) else $error("column strobe too soon");
	property p_refresh;
		s_row_only |-> (!mux_address[7] && $stable(column_strobe_n)) [*4];
	endproperty
	a_refresh: assert property (p_refresh) else $error("bad refresh cycle");
	property p_write;
		!write_strobe_n |-> !row_strobe_n;
	endproperty
	a_write: assert property (p_write) else $error("write strobe without row");
	property p_init;
		!init_done |-> column_strobe_n && write_strobe_n && !req_ready;
	endproperty
	a_init: assert property (p_init) else $error("activity before init");
	property p_early;
		$fell(row_strobe_n) && $past(req_valid && req_ready && req_cmd == CMD_WRITE)
			|-> !write_strobe_n && column_strobe_n;
	endproperty
	a_early: assert property (p_early) else $error("write not early");
	property p_gap;
		init_done |-> gap_ff < REFRESH_INTERVAL + 40;
	endproperty
	a_gap: assert property (p_gap) else $error("refresh overdue");
	property p_rsp;
		req_valid && req_ready && req_cmd == CMD_READ |-> ##[9:12] rsp_valid;
	endproperty
	a_rsp: assert property (p_rsp) else $error("read answer missing");
endmodule

// ==== verification/dram_ctrl_tb.sv ====
// Self-checking testbench of the dynamic memory controller.
`timescale 1ns/100ps
module dram_ctrl_tb;
	import dram_ctrl_pkg::*;
	logic clk, rst, req_valid, req_ready, req_page, rsp_valid, init_done;
	logic row_strobe_n, column_strobe_n, write_strobe_n;
	logic [1:0] req_cmd;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, write_data_in;
	logic [HALF_W-1:0] mux_address;
	wire logic [DATA_W-1:0] read_data_out;
	int miscompares, checks, row_falls;
	dram_ctrl #(.POWERUP_CYCLES(10), .REFRESH_INTERVAL(50)) dram_ctrl_i (.clk(clk), .rst(rst),
		.req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
		.req_wdata(req_wdata), .req_page(req_page), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .init_done(init_done), .row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
		.mux_address(mux_address), .write_data_in(write_data_in),
		.read_data_out(read_data_out));
	dram_model #(.T_ACC_NS(90)) dram_model_i (.row_strobe_n(row_strobe_n),
		.column_strobe_n(column_strobe_n), .write_strobe_n(write_strobe_n),
		.mux_address(mux_address), .write_data_in(write_data_in),
		.read_data_out(read_data_out));
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(negedge row_strobe_n)
		row_falls++;
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic drive(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d,
		input logic p);
		@(posedge clk);
		req_valid <= 1'b1;
		req_cmd <= c;
		req_addr <= a;
		req_wdata <= d;
		req_page <= p;
	endtask
	task automatic take;
		int n;
		n = 0;
		do
			@(posedge clk);
		while (req_ready !== 1'b1 && ++n < 400);
		check(req_ready, 1'b1);
	endtask
	task automatic send(input logic [1:0] c, input logic [15:0] a, input logic [7:0] d);
		drive(c, a, d, 1'b0);
		take();
		req_valid <= 1'b0;
	endtask
	task automatic get(input logic [7:0] exp);
		int n;
		n = 0;
		while (rsp_valid !== 1'b1 && n++ < 40)
			@(posedge clk);
		check(rsp_valid, 1'b1);
		check(rsp_rdata, exp);
		@(posedge clk);
	endtask
	task automatic t_init;
		int n;
		n = 0;
		while (init_done !== 1'b1 && n++ < 500)
			@(posedge clk);
		check(init_done, 1'b1);
		check(row_falls >= DUMMY_CYCLES, 1'b1);
	endtask
	task automatic t_rw;
		logic [15:0] a[4];
		a = '{16'h0000, 16'hffff, 16'h80a5, 16'h7f5a};
		foreach (a[i])
			send(CMD_WRITE, a[i], a[i][7:0] ^ 8'h3c);
		foreach (a[i])
		begin
			send(CMD_READ, a[i], 8'h00);
			get(a[i][7:0] ^ 8'h3c);
		end
		send(CMD_RMW, 16'h80a5, 8'he1);
		get(8'h99);
		send(CMD_READ, 16'h80a5, 8'h00);
		get(8'he1);
	endtask
	task automatic t_refresh;
		int r0;
		int n;
		r0 = row_falls;
		repeat (120) @(posedge clk);
		check(row_falls - r0 >= 2, 1'b1);
		send(CMD_READ, 16'h0000, 8'h00);
		get(8'h3c);
		r0 = row_falls;
		n = 0;
		while (row_falls == r0 && n++ < 200)
			@(posedge clk);
	endtask
	task automatic t_page;
		int r0;
		int n;
		// Start just after an idle refresh so that no refresh falls due during the page.
		r0 = row_falls;
		n = 0;
		while (row_falls == r0 && n++ < 200)
			@(posedge clk);
		send(CMD_WRITE, 16'h7f5b, 8'h5b);
		drive(CMD_READ, 16'h7f5a, 8'h00, 1'b1);
		take();
		req_addr <= 16'h7f5b;
		get(8'h66);
		r0 = row_falls;
		n = 0;
		while (column_strobe_n !== 1'b0 && n++ < 40)
			@(posedge clk);
		req_valid <= 1'b0;
		get(8'h5b);
		check(row_falls - r0, 0);
	endtask
	initial
	begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = CMD_READ;
		req_addr = 16'h0000;
		req_wdata = 8'h00;
		req_page = 1'b0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		t_init();
		t_rw();
		t_refresh();
		t_page();
		final_report();
	end
	initial
	begin
		repeat (5000) @(posedge clk);
		miscompares++;
		final_report();
	end
endmodule
bind dram_ctrl dram_ctrl_monitor #(.REFRESH_INTERVAL(REFRESH_INTERVAL)) dram_ctrl_monitor_i (
	.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
	.req_addr(req_addr), .rsp_valid(rsp_valid), .init_done(init_done),
	.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
	.write_strobe_n(write_strobe_n), .mux_address(mux_address));

// ==== verification/dram_model.sv ====
// Behavioural model of the byte-wide dynamic memory.
`timescale 1ns/100ps
module dram_model
	import dram_ctrl_pkg::*;
#(
	parameter int T_ACC_NS = 90
)
(
	// Memory pins.
	input wire logic row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [dram_ctrl_pkg::HALF_W-1:0] mux_address,
	input wire logic [dram_ctrl_pkg::DATA_W-1:0] write_data_in,
	output wire logic [dram_ctrl_pkg::DATA_W-1:0] read_data_out
);
	import dram_ctrl_pkg::*;
	logic [DATA_W-1:0] mem [0:65535];
	logic [HALF_W-1:0] row_ff, orow_ff, col_ff;
	logic early_ff = 1'b0;
	logic [DATA_W-1:0] last_ff = 8'h00;
	wire logic [DATA_W-1:0] q_now;
	always @(negedge row_strobe_n)
		row_ff <= mux_address;
	always @(negedge column_strobe_n)
	begin
		col_ff <= mux_address;
		orow_ff <= row_ff;
		early_ff <= !write_strobe_n;
	end
	always @(negedge column_strobe_n or negedge write_strobe_n)
		#1 if (!column_strobe_n && !write_strobe_n)
			mem[{orow_ff, col_ff}] = write_data_in;
	always @(posedge column_strobe_n)
		last_ff <= ~read_data_out;
	assign q_now = (!column_strobe_n && !early_ff) ? mem[{orow_ff, col_ff}] : last_ff;
	assign #(T_ACC_NS) read_data_out = q_now;
endmodule
